//--- hdl/fifo_ctl_pkg.sv
// constants and carrier types for the dual-port fifo control block
// assumes one system clock; both port clocks arrive as sampled pins
package fifo_ctl_pkg;

  localparam int DATA_W   = 36;
  localparam int ADDR_W   = 10;
  localparam int CNT_W    = ADDR_W + 1;
  localparam int OFF_W    = 11;
  localparam int SER_BITS = 2 * OFF_W;
  localparam int SCNT_W   = 5;

  localparam logic [CNT_W-1:0]  FULL_CNT = 11'h400;
  localparam logic [SCNT_W-1:0] SER_LAST = 5'h15;

  // offset select codes {select2, select1, select0}
  localparam logic [2:0] SEL_PRE8    = 3'h0;
  localparam logic [2:0] SEL_PRE16   = 3'h1;
  localparam logic [2:0] SEL_PRE64   = 3'h2;
  localparam logic [2:0] SEL_PRE256  = 3'h3;
  localparam logic [2:0] SEL_PRE1024 = 3'h4;
  localparam logic [2:0] SEL_PAR     = 3'h5;
  localparam logic [2:0] SEL_SER     = 3'h6;

  localparam logic [OFF_W-1:0] PRE_8    = 11'h008;
  localparam logic [OFF_W-1:0] PRE_16   = 11'h010;
  localparam logic [OFF_W-1:0] PRE_64   = 11'h040;
  localparam logic [OFF_W-1:0] PRE_256  = 11'h100;
  localparam logic [OFF_W-1:0] PRE_1024 = 11'h400;

  // register map, byte addresses
  localparam int WB_ADR_W = 8;
  localparam logic [WB_ADR_W-1:0] REG_CTRL   = 8'h00;
  localparam logic [WB_ADR_W-1:0] REG_STATUS = 8'h04;
  localparam logic [WB_ADR_W-1:0] REG_XOFF   = 8'h08;
  localparam logic [WB_ADR_W-1:0] REG_YOFF   = 8'h0c;
  localparam int CTRL_FLUSH = 0;
  localparam int STAT_FLAGS = 16;

  typedef enum logic [1:0] {PRG_SERIAL, PRG_PAR_X, PRG_PAR_Y, PRG_DONE} prog_t;

  typedef struct packed {
    logic              a_clk;
    logic              a_en;
    logic              a_cs_n;
    logic              a_wr;
    logic              a_mb;
    logic [DATA_W-1:0] a_d;
    logic              b_clk;
    logic              b_en;
    logic              b_cs_n;
    logic              b_rd;
    logic              b_mb;
    logic [DATA_W-1:0] b_d;
    logic              std_mode;
    logic [2:0]        fs;
  } pins_t;

endpackage

//--- hdl/fifo_port_ctl.sv
// dual-port fifo control: port a writes, port b reads, flags, offsets, mailboxes
// assumes all pins asynchronous to clk_i; port clocks much slower than clk_i
// Summary of operation
// - standard mode: port b flag shows fifo not empty
// - fall-through mode: port b flag shows a word waiting on port b outputs
// - port b flag changes only on port b clock rising edges
// - standard mode: port a flag shows fifo not full
// - fall-through mode: port a flag shows space to write
// - port a flag changes only on port a clock rising edges
// - select inputs during reset pick preset, parallel or serial offset load
// - serial load: port a edge with serial enable low shifts data bit in
// - first serial bit is almost-full msb, last is almost-empty lsb
// - port a mailbox select steers port a access to a mailbox
// - port b mailbox select steers port b access to a mailbox
// - port b outputs show first mailbox when selected, else fifo data
// - almost-empty low while word count at or below its offset
// - almost-full low while free count at or below its offset
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module fifo_port_ctl
(
  // system
  input  wire logic                                clk_i,
  input  wire logic                                rst_i,
  // wishbone slave
  input  wire logic                                wb_cyc_i,
  input  wire logic                                wb_stb_i,
  input  wire logic                                wb_we_i,
  input  wire logic [fifo_ctl_pkg::WB_ADR_W-1:0]   wb_adr_i,
  input  wire logic [3:0]                          wb_sel_i,
  input  wire logic [31:0]                         wb_dat_i,
  output logic      [31:0]                         wb_dat_o,
  output logic                                     wb_ack_o,
  // port a
  input  wire logic                                port_a_clock_i,
  input  wire logic                                port_a_enable_i,
  input  wire logic                                port_a_chip_select_n_i,
  input  wire logic                                port_a_write_i,
  input  wire logic                                port_a_mailbox_select_i,
  input  wire logic [fifo_ctl_pkg::DATA_W-1:0]     port_a_data_i,
  output logic      [fifo_ctl_pkg::DATA_W-1:0]     port_a_data_o,
  output logic                                     port_a_data_oe_n_o,
  output logic                                     full_or_input_ready_o,
  output logic                                     almost_full_flag_n_o,
  // port b
  input  wire logic                                port_b_clock_i,
  input  wire logic                                port_b_enable_i,
  input  wire logic                                port_b_chip_select_n_i,
  input  wire logic                                port_b_read_i,
  input  wire logic                                port_b_mailbox_select_i,
  input  wire logic [fifo_ctl_pkg::DATA_W-1:0]     port_b_data_i,
  output logic      [fifo_ctl_pkg::DATA_W-1:0]     port_b_data_o,
  output logic                                     port_b_data_oe_n_o,
  output logic                                     empty_or_output_ready_o,
  output logic                                     almost_empty_flag_n_o,
  // configuration
  input  wire logic                                fall_through_mode_n_i,
  input  wire logic                                offset_select0_serial_data_i,
  input  wire logic                                offset_select1_serial_enable_n_i,
  input  wire logic                                offset_select2_i
);

  // ==========================================================
  // state
  typedef struct packed {
    fifo_ctl_pkg::pins_t                   s1;
    fifo_ctl_pkg::pins_t                   s2;
    logic                                  a_clk_q;
    logic                                  b_clk_q;
    logic [fifo_ctl_pkg::ADDR_W-1:0]       wr_ptr;
    logic [fifo_ctl_pkg::ADDR_W-1:0]       rd_ptr;
    logic [fifo_ctl_pkg::CNT_W-1:0]        cnt;
    logic [fifo_ctl_pkg::OFF_W-1:0]        y_off;
    logic [fifo_ctl_pkg::OFF_W-1:0]        x_off;
    fifo_ctl_pkg::prog_t                   prog;
    logic [fifo_ctl_pkg::SCNT_W-1:0]       ser_cnt;
    logic [fifo_ctl_pkg::DATA_W-1:0]       mb1;
    logic [fifo_ctl_pkg::DATA_W-1:0]       mb2;
    logic [fifo_ctl_pkg::DATA_W-1:0]       ob;
    logic                                  ob_vld;
    logic                                  eor;
    logic                                  fir;
    logic                                  ae_n;
    logic                                  af_n;
    logic [fifo_ctl_pkg::DATA_W-1:0]       a_dout;
    logic                                  a_oe_n;
    logic [fifo_ctl_pkg::DATA_W-1:0]       b_dout;
    logic                                  b_oe_n;
    logic                                  ack;
    logic [31:0]                           rdat;
  } state_t;

  state_t                           st_reg;
  state_t                           st_next;
  fifo_ctl_pkg::pins_t              pins;
  logic [fifo_ctl_pkg::DATA_W-1:0]  mem [0:(1<<fifo_ctl_pkg::ADDR_W)-1];
  logic [fifo_ctl_pkg::DATA_W-1:0]  mem_q;
  logic                             a_edge;
  logic                             b_edge;
  logic                             a_go;
  logic                             b_go;
  logic                             fifo_wr;
  logic                             take;
  logic                             rd_ld;
  logic                             wb_req;
  logic                             std_md;
  logic [fifo_ctl_pkg::SER_BITS-1:0] chain;

  assign pins = '{a_clk: port_a_clock_i, a_en: port_a_enable_i,
                  a_cs_n: port_a_chip_select_n_i, a_wr: port_a_write_i,
                  a_mb: port_a_mailbox_select_i, a_d: port_a_data_i,
                  b_clk: port_b_clock_i, b_en: port_b_enable_i,
                  b_cs_n: port_b_chip_select_n_i, b_rd: port_b_read_i,
                  b_mb: port_b_mailbox_select_i, b_d: port_b_data_i,
                  std_mode: fall_through_mode_n_i,
                  fs: {offset_select2_i, offset_select1_serial_enable_n_i,
                       offset_select0_serial_data_i}};

  assign mem_q = mem[st_reg.rd_ptr];
  assign chain = {st_reg.y_off, st_reg.x_off};

  // ==========================================================
  // next state
  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = pins;
    st_next.s2 = st_reg.s1;
    st_next.a_clk_q = st_reg.s2.a_clk;
    st_next.b_clk_q = st_reg.s2.b_clk;
    std_md = st_reg.s2.std_mode;
    a_edge = st_reg.s2.a_clk & ~st_reg.a_clk_q;
    b_edge = st_reg.s2.b_clk & ~st_reg.b_clk_q;
    a_go = a_edge & st_reg.s2.a_en & ~st_reg.s2.a_cs_n;
    b_go = b_edge & st_reg.s2.b_en & ~st_reg.s2.b_cs_n;
    fifo_wr = a_go & st_reg.s2.a_wr & ~st_reg.s2.a_mb & (st_reg.cnt != fifo_ctl_pkg::FULL_CNT)
              & (st_reg.prog == fifo_ctl_pkg::PRG_DONE);
    take = b_go & st_reg.s2.b_rd & ~st_reg.s2.b_mb & (std_md | st_reg.ob_vld);
    rd_ld = b_edge & (st_reg.cnt != '0) & (std_md ? take : (~st_reg.ob_vld | take));

    // fifo storage
    // fall-through keeps one word in the output register, and the count leaves it out
    if (fifo_wr)
      st_next.wr_ptr = st_reg.wr_ptr + 1'h1;
    if (rd_ld)
    begin
      st_next.rd_ptr = st_reg.rd_ptr + 1'h1;
      st_next.ob = mem_q;
    end
    case ({fifo_wr, rd_ld})
      2'h2: st_next.cnt = st_reg.cnt + 1'h1;
      2'h1: st_next.cnt = st_reg.cnt - 1'h1;
      default: st_next.cnt = st_reg.cnt;
    endcase
    if (rd_ld)
      st_next.ob_vld = 1'h1;
    else if (take)
      st_next.ob_vld = 1'h0;

    // software flush of the queue, offsets kept
    wb_req = wb_cyc_i & wb_stb_i & ~st_reg.ack;
    if (wb_req && wb_we_i && wb_sel_i[0] && wb_adr_i == fifo_ctl_pkg::REG_CTRL
        && wb_dat_i[fifo_ctl_pkg::CTRL_FLUSH])
    begin
      st_next.wr_ptr = '0;
      st_next.rd_ptr = '0;
      st_next.cnt = '0;
      st_next.ob_vld = 1'h0;
    end

    // port b flags
    if (b_edge)
    begin
      st_next.eor = std_md ? (st_next.cnt != '0) : st_next.ob_vld;
      st_next.ae_n = st_next.cnt > st_reg.x_off;
    end
    // port a flags
    if (a_edge)
    begin
      st_next.fir = st_next.cnt != fifo_ctl_pkg::FULL_CNT;
      st_next.af_n = (fifo_ctl_pkg::FULL_CNT - st_next.cnt) > st_reg.y_off;
    end

    // mailboxes
    if (a_go && st_reg.s2.a_wr && st_reg.s2.a_mb)
      st_next.mb1 = st_reg.s2.a_d;
    if (b_go && !st_reg.s2.b_rd && st_reg.s2.b_mb)
      st_next.mb2 = st_reg.s2.b_d;

    // pin drivers
    // data outputs move only on port clock edges, so a reader sees them stand a period
    if (a_edge)
    begin
      st_next.a_oe_n = st_reg.s2.a_cs_n | st_reg.s2.a_wr;
      st_next.a_dout = st_reg.s2.a_mb ? st_next.mb2 : '0;
    end
    if (b_edge)
    begin
      st_next.b_oe_n = st_reg.s2.b_cs_n | ~st_reg.s2.b_rd;
      st_next.b_dout = st_reg.s2.b_mb ? st_next.mb1 : st_next.ob;
    end

    // offset programming
    case (st_reg.prog)
      fifo_ctl_pkg::PRG_SERIAL:
        if (a_edge && !st_reg.s2.fs[1])
        begin
          {st_next.y_off, st_next.x_off} = {chain[fifo_ctl_pkg::SER_BITS-2:0], st_reg.s2.fs[0]};
          st_next.ser_cnt = st_reg.ser_cnt + 1'h1;
          if (st_reg.ser_cnt == fifo_ctl_pkg::SER_LAST)
            st_next.prog = fifo_ctl_pkg::PRG_DONE;
        end
      fifo_ctl_pkg::PRG_PAR_X:
        if (a_go && st_reg.s2.a_wr && !st_reg.s2.a_mb)
        begin
          st_next.x_off = st_reg.s2.a_d[fifo_ctl_pkg::OFF_W-1:0];
          st_next.prog = fifo_ctl_pkg::PRG_PAR_Y;
        end
      fifo_ctl_pkg::PRG_PAR_Y:
        if (a_go && st_reg.s2.a_wr && !st_reg.s2.a_mb)
        begin
          st_next.y_off = st_reg.s2.a_d[fifo_ctl_pkg::OFF_W-1:0];
          st_next.prog = fifo_ctl_pkg::PRG_DONE;
        end
      default: st_next.prog = st_reg.prog;
    endcase

    // wishbone slave
    st_next.ack = wb_req;
    if (wb_req)
    begin
      case (wb_adr_i)
        fifo_ctl_pkg::REG_STATUS:
          st_next.rdat = 32'(st_reg.cnt) | (32'({st_reg.prog == fifo_ctl_pkg::PRG_DONE, st_reg.af_n,
                         st_reg.ae_n, st_reg.fir, st_reg.eor}) << fifo_ctl_pkg::STAT_FLAGS);
        fifo_ctl_pkg::REG_XOFF: st_next.rdat = 32'(st_reg.x_off);
        fifo_ctl_pkg::REG_YOFF: st_next.rdat = 32'(st_reg.y_off);
        default: st_next.rdat = 32'h0000_0000;
      endcase
    end

    // reset: pick the offset programming method from the select pins
    if (rst_i)
    begin
      st_next = '0;
      st_next.s1 = pins;
      st_next.s2 = st_reg.s1;
      // edge detectors follow the pin level so release shows no false edge
      st_next.a_clk_q = st_reg.s2.a_clk;
      st_next.b_clk_q = st_reg.s2.b_clk;
      st_next.fir = 1'h1;
      st_next.af_n = 1'h1;
      st_next.a_oe_n = 1'h1;
      st_next.b_oe_n = 1'h1;
      st_next.prog = fifo_ctl_pkg::PRG_DONE;
      case (st_reg.s2.fs)
        fifo_ctl_pkg::SEL_PRE16:   st_next.x_off = fifo_ctl_pkg::PRE_16;
        fifo_ctl_pkg::SEL_PRE64:   st_next.x_off = fifo_ctl_pkg::PRE_64;
        fifo_ctl_pkg::SEL_PRE256:  st_next.x_off = fifo_ctl_pkg::PRE_256;
        fifo_ctl_pkg::SEL_PRE1024: st_next.x_off = fifo_ctl_pkg::PRE_1024;
        fifo_ctl_pkg::SEL_PAR:     st_next.prog = fifo_ctl_pkg::PRG_PAR_X;
        fifo_ctl_pkg::SEL_SER:     st_next.prog = fifo_ctl_pkg::PRG_SERIAL;
        default:                   st_next.x_off = fifo_ctl_pkg::PRE_8;
      endcase
      st_next.y_off = st_next.x_off;
    end
  end

  always_ff @(posedge clk_i)
  begin
    st_reg <= st_next;
  end

  // storage array, written from the synchronised port a data
  always_ff @(posedge clk_i)
  begin
    if (fifo_wr && !rst_i)
      mem[st_reg.wr_ptr] <= st_reg.s2.a_d;
  end

  // ==========================================================
  // outputs
  assign wb_dat_o = st_reg.rdat;
  assign wb_ack_o = st_reg.ack;
  assign port_a_data_o = st_reg.a_dout;
  assign port_a_data_oe_n_o = st_reg.a_oe_n;
  assign full_or_input_ready_o = st_reg.fir;
  assign almost_full_flag_n_o = st_reg.af_n;
  assign port_b_data_o = st_reg.b_dout;
  assign port_b_data_oe_n_o = st_reg.b_oe_n;
  assign empty_or_output_ready_o = st_reg.eor;
  assign almost_empty_flag_n_o = st_reg.ae_n;

  // ==========================================================
  // checks
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence ser_bit_s;
    a_edge && st_reg.prog == fifo_ctl_pkg::PRG_SERIAL && !st_reg.s2.fs[1];
  endsequence

  std_empty_a: assert property (b_edge && std_md && st_next.cnt == '0 |=> !empty_or_output_ready_o)
    else $error("empty flag not shown");
  fall_through_mode_ready_a: assert property (b_edge && !std_md |=> empty_or_output_ready_o == st_reg.ob_vld)
    else $error("output ready does not match held word");
  eor_hold_a: assert property (!b_edge |=> $stable(empty_or_output_ready_o))
    else $error("port b flag moved off edge");
  full_flag_a: assert property (a_edge && st_next.cnt == fifo_ctl_pkg::FULL_CNT |=> !full_or_input_ready_o)
    else $error("full not shown");
  fir_hold_a: assert property (!a_edge |=> $stable(full_or_input_ready_o))
    else $error("port a flag moved off edge");
  serial_shift_a: assert property (ser_bit_s |=> chain[0] == $past(st_reg.s2.fs[0])
                                   && chain[fifo_ctl_pkg::SER_BITS-1:1] == $past(chain[fifo_ctl_pkg::SER_BITS-2:0]))
    else $error("serial chain did not shift");
  mailbox_wr_a: assert property (a_go && st_reg.s2.a_wr && st_reg.s2.a_mb |=> st_reg.mb1 == $past(st_reg.s2.a_d)
                                 && ($stable(st_reg.cnt) || st_reg.cnt == $past(st_reg.cnt) - 1'h1))
    else $error("mailbox write lost");
  mail2_wr_a: assert property (b_go && !st_reg.s2.b_rd && st_reg.s2.b_mb |=> st_reg.mb2 == $past(st_reg.s2.b_d))
    else $error("port b mailbox write lost");
  input_ready_a: assert property (a_edge && st_next.cnt != fifo_ctl_pkg::FULL_CNT |=> full_or_input_ready_o)
    else $error("space not shown on port a flag");
  b_mail_out_a: assert property (b_edge && st_reg.s2.b_mb |=> port_b_data_o == st_reg.mb1)
    else $error("port b not showing mailbox");
  almost_empty_a: assert property (b_edge && st_next.cnt <= st_reg.x_off |=> !almost_empty_flag_n_o)
    else $error("almost empty not low");
  almost_full_a: assert property (a_edge && fifo_ctl_pkg::FULL_CNT - st_next.cnt <= st_reg.y_off
                                  |=> !almost_full_flag_n_o)
    else $error("almost full not low");

endmodule

`default_nettype wire

//--- bench/port_party.sv
// partner model: the processors on port a and port b plus the strap pins
// assumes the bench calls its tasks one at a time; port clocks run free
`timescale 1ns/1ns
`default_nettype none

module port_party
(
  // system
  input  wire logic                              clk_i,
  // pins towards the block and its data outputs
  output fifo_ctl_pkg::pins_t                    pins_o,
  input  wire logic [fifo_ctl_pkg::DATA_W-1:0]   a_q_i,
  input  wire logic [fifo_ctl_pkg::DATA_W-1:0]   b_q_i
);
  logic [2:0] ph = 3'h0;
  logic [2:0] bp;

  initial pins_o = '{a_cs_n: 1'b1, b_cs_n: 1'b1, std_mode: 1'b1, default: '0};
  assign bp = ph + 3'h2;

  // =========================================
  // port clocks, 320 ns, port b two cycles ahead of port a
  always @(posedge clk_i)
  begin
    ph <= ph + 3'h1;
    pins_o.a_clk <= ph[2];
    pins_o.b_clk <= bp[2];
  end

  function automatic logic pclk(input logic b);
    return b ? pins_o.b_clk : pins_o.a_clk;
  endfunction

  task automatic edge_of(input logic b, input logic lvl);
    logic c;
    do
    begin
      c = pclk(b);
      @(pins_o.a_clk or pins_o.b_clk);
    end
    while (c === pclk(b) || pclk(b) !== lvl);
  endtask

  // =========================================
  // strap pins, held static while reset runs
  task automatic set_cfg(input logic [2:0] c, input logic s);
    pins_o.fs <= c;
    pins_o.std_mode <= s;
  endtask

  task automatic drive(input logic b, en, cs_n, dir, mb, input logic [35:0] d);
    if (b)
      {pins_o.b_en, pins_o.b_cs_n, pins_o.b_rd, pins_o.b_mb, pins_o.b_d} <= {en, cs_n, dir, mb, d};
    else
      {pins_o.a_en, pins_o.a_cs_n, pins_o.a_wr, pins_o.a_mb, pins_o.a_d} <= {en, cs_n, dir, mb, d};
  endtask

  // =========================================
  // one transfer: set up after a fall, hold over the rise, release, sample
  task automatic xfer(input logic b, en, dir, mb, input logic [35:0] d, output logic [35:0] q);
    edge_of(b, 1'b0);
    drive(b, en, 1'b0, dir, mb, d);
    edge_of(b, 1'b1);
    edge_of(b, 1'b0);
    drive(b, 1'b0, 1'b1, dir, 1'b0, ~d);
    edge_of(b, 1'b1);
    @(negedge clk_i);
    q = b ? b_q_i : a_q_i;
  endtask

  // serial offsets, first bit is the almost-full msb; one idle edge midway
  task automatic ser_load(input logic [fifo_ctl_pkg::SER_BITS-1:0] bits);
    int k;
    for (int i = 0; i <= fifo_ctl_pkg::SER_BITS; i++)
    begin
      k = fifo_ctl_pkg::SER_BITS - 1 - i + ((i > 11) ? 1 : 0);
      edge_of(1'b0, 1'b0);
      pins_o.fs[1] <= (i == 11);
      pins_o.fs[0] <= (i == 11) ? ~bits[0] : bits[k];
    end
    edge_of(1'b0, 1'b0);
    pins_o.fs[1] <= 1'b1;
  endtask
endmodule

`default_nettype wire

//--- bench/test_fifo_port_ctl.sv
// self-checking bench for the dual-port fifo control block
// assumes port_party owns every port pin; the wishbone master lives here
`timescale 1ns/1ns
`default_nettype none

module test_fifo_port_ctl;
  logic                clk_i = 1'b0;
  logic                rst_i = 1'b1;
  logic                cyc = 1'b0;
  logic                stb = 1'b0;
  logic                we = 1'b0;
  logic [7:0]          adr = 8'h00;
  logic [31:0]         wdat = 32'h0000_0000;
  logic [31:0]         rdat;
  logic                ack;
  logic [35:0]         a_q;
  logic [35:0]         b_q;
  logic                fir, af_n, eor, ae_n, a_oe_n, b_oe_n;
  fifo_ctl_pkg::pins_t pins;
  int                  num_errors = 0;
  int                  n_checks = 0;
  int                  since_a = 9;
  int                  since_b = 9;
  logic                pa_q, pb_q, rs_q, fir_q, eor_q;

  always #20 clk_i = ~clk_i;

  port_party party (.clk_i(clk_i), .pins_o(pins), .a_q_i(a_q), .b_q_i(b_q));

  fifo_port_ctl dut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .port_a_clock_i(pins.a_clk), .port_a_enable_i(pins.a_en), .port_a_chip_select_n_i(pins.a_cs_n),
    .port_a_write_i(pins.a_wr), .port_a_mailbox_select_i(pins.a_mb), .port_a_data_i(pins.a_d),
    .port_a_data_o(a_q), .port_a_data_oe_n_o(a_oe_n), .full_or_input_ready_o(fir), .almost_full_flag_n_o(af_n),
    .port_b_clock_i(pins.b_clk), .port_b_enable_i(pins.b_en), .port_b_chip_select_n_i(pins.b_cs_n),
    .port_b_read_i(pins.b_rd), .port_b_mailbox_select_i(pins.b_mb), .port_b_data_i(pins.b_d),
    .port_b_data_o(b_q), .port_b_data_oe_n_o(b_oe_n), .empty_or_output_ready_o(eor), .almost_empty_flag_n_o(ae_n),
    .fall_through_mode_n_i(pins.std_mode), .offset_select0_serial_data_i(pins.fs[0]),
    .offset_select1_serial_enable_n_i(pins.fs[1]), .offset_select2_i(pins.fs[2]));

  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // =========================================
  // flags may only move within a few cycles of their own port clock rising
  always @(negedge clk_i)
  begin
    since_a = (pins.a_clk && !pa_q) ? 0 : since_a + 1;
    since_b = (pins.b_clk && !pb_q) ? 0 : since_b + 1;
    if (!rst_i && !rs_q && fir !== fir_q)
      check("fir_timing", since_a <= 6, 1'b1);
    if (!rst_i && !rs_q && eor !== eor_q)
      check("eor_timing", since_b <= 6, 1'b1);
    {pa_q, pb_q, rs_q, fir_q, eor_q} = {pins.a_clk, pins.b_clk, rst_i, fir, eor};
  end

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    n = 0;
    // ack and read data are taken as sampled at the rising edge
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
    begin
      num_errors++;
      tally_and_finish();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic do_reset(input logic [2:0] code, input logic std);
    @(posedge clk_i);
    party.set_cfg(code, std);
    rst_i <= 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  function automatic logic [35:0] pat(input int i);
    return {i[17:0], ~i[17:0]};
  endfunction

  task automatic flags(input int n);
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    check("empty_flag", eor, n > 0);
    check("full_flag", fir, n < int'(fifo_ctl_pkg::FULL_CNT));
    check("almost_empty", ae_n, n > 8);
    check("almost_full", af_n, int'(fifo_ctl_pkg::FULL_CNT) - n > 8);
  endtask

  // =========================================
  // scenarios
  localparam logic [2:0] CODES [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  localparam logic [10:0] PRES [6] = '{11'h008, 11'h010, 11'h040, 11'h100, 11'h400, 11'h008};

  task automatic t_presets();
    logic [31:0] r;
    for (int i = 0; i < 6; i++)
    begin
      do_reset(CODES[i], 1'b1);
      wb(1'b0, fifo_ctl_pkg::REG_XOFF, 32'h0000_0000, r);
      check("preset_x", r[10:0], PRES[i]);
      wb(1'b0, fifo_ctl_pkg::REG_YOFF, 32'h0000_0000, r);
      check("preset_y", r[10:0], PRES[i]);
    end
    $display("preset offsets done");
  endtask

  task automatic t_program();
    logic [31:0] r;
    logic [35:0] q;
    do_reset(fifo_ctl_pkg::SEL_SER, 1'b1);
    party.xfer(1'b0, 1'b1, 1'b1, 1'b0, pat(5), q);
    wb(1'b0, fifo_ctl_pkg::REG_STATUS, 32'h0000_0000, r);
    check("unprogrammed", {r[20], r[10:0]}, 12'h000);
    party.ser_load({11'h15b, 11'h2a5});
    wb(1'b0, fifo_ctl_pkg::REG_XOFF, 32'h0000_0000, r);
    check("serial_x", r[10:0], 11'h2a5);
    wb(1'b0, fifo_ctl_pkg::REG_YOFF, 32'h0000_0000, r);
    check("serial_y", r[10:0], 11'h15b);
    wb(1'b0, fifo_ctl_pkg::REG_STATUS, 32'h0000_0000, r);
    check("serial_done", r[20], 1'b1);
    do_reset(fifo_ctl_pkg::SEL_PAR, 1'b1);
    party.xfer(1'b0, 1'b1, 1'b1, 1'b0, 36'h0_0000_0033, q);
    party.xfer(1'b0, 1'b1, 1'b1, 1'b0, 36'h0_0000_07c4, q);
    wb(1'b1, fifo_ctl_pkg::REG_XOFF, 32'h0000_0001, r);
    wb(1'b0, fifo_ctl_pkg::REG_XOFF, 32'h0000_0000, r);
    check("parallel_x", r[10:0], 11'h033);
    wb(1'b0, fifo_ctl_pkg::REG_YOFF, 32'h0000_0000, r);
    check("parallel_y", r[10:0], 11'h7c4);
    party.xfer(1'b0, 1'b1, 1'b1, 1'b0, pat(1), q);
    wb(1'b0, fifo_ctl_pkg::REG_STATUS, 32'h0000_0000, r);
    check("word_stored", r[10:0], 11'h001);
    wb(1'b1, fifo_ctl_pkg::REG_CTRL, 32'h0000_0001, r);
    wb(1'b0, fifo_ctl_pkg::REG_STATUS, 32'h0000_0000, r);
    check("flushed", r[10:0], 11'h000);
    wb(1'b0, 8'h40, 32'h0000_0000, r);
    check("unmapped", r, 32'h0000_0000);
    $display("offset programming done");
  endtask

  task automatic t_standard();
    logic [31:0] r;
    logic [35:0] q;
    do_reset(fifo_ctl_pkg::SEL_PRE8, 1'b1);
    party.xfer(1'b0, 1'b0, 1'b1, 1'b0, pat(0), q);
    flags(0);
    for (int i = 1; i <= 1025; i++)
    begin
      party.xfer(1'b0, 1'b1, 1'b1, 1'b0, pat(i), q);
      flags((i > 1024) ? 1024 : i);
    end
    wb(1'b0, fifo_ctl_pkg::REG_STATUS, 32'h0000_0000, r);
    check("full_count", r[10:0], fifo_ctl_pkg::FULL_CNT);
    for (int i = 1; i <= 1024; i++)
    begin
      party.xfer(1'b1, 1'b1, 1'b1, 1'b0, 36'h0_0000_0000, q);
      check("fifo_word", q, pat(i));
      flags(1024 - i);
    end
    $display("standard fill and drain done");
  endtask

  task automatic t_fall_through();
    logic [31:0] r;
    logic [35:0] q;
    do_reset(fifo_ctl_pkg::SEL_PRE8, 1'b0);
    party.xfer(1'b0, 1'b1, 1'b1, 1'b0, pat(7), q);
    repeat (24) @(posedge clk_i);
    @(negedge clk_i);
    check("ready_flag", eor, 1'b1);
    check("fall_word", b_q, pat(7));
    check("input_ready", fir, 1'b1);
    party.xfer(1'b0, 1'b1, 1'b1, 1'b1, 36'h9_8765_4321, q);
    wb(1'b0, fifo_ctl_pkg::REG_STATUS, 32'h0000_0000, r);
    check("mail_count", r[10:0], 11'h000);
    party.xfer(1'b1, 1'b1, 1'b1, 1'b1, 36'h0_0000_0000, q);
    check("first_mailbox", q, 36'h9_8765_4321);
    check("b_drive", b_oe_n, 1'b0);
    party.xfer(1'b1, 1'b1, 1'b1, 1'b0, 36'h0_0000_0000, q);
    check("ready_clear", eor, 1'b0);
    party.xfer(1'b1, 1'b1, 1'b0, 1'b1, 36'h1_2345_6789, q);
    party.xfer(1'b0, 1'b1, 1'b0, 1'b1, 36'h0_0000_0000, q);
    check("second_mailbox", q, 36'h1_2345_6789);
    check("a_drive", a_oe_n, 1'b0);
    $display("fall-through and mailbox done");
  endtask

  initial
  begin
    repeat (100000) @(posedge clk_i);
    num_errors++;
    tally_and_finish();
  end

  initial
  begin
    t_presets();
    t_program();
    t_fall_through();
    t_standard();
    tally_and_finish();
  end
endmodule

`default_nettype wire
